// *** hdl/qpl_pkg.sv ***
// qpl_pkg: constants and types shared by the pixel link source controller.
// assumes a 200 MHz system clock; raster counts are in lane clocks and lines, all other counts in system clock cycles.
package qpl_pkg;

  // ----------------------------------------------------------------
  // link shape
  // ----------------------------------------------------------------
  localparam int LANES = 5;
  localparam int SLOTS = 7;
  localparam int COLOR_W = 10;
  localparam logic [2:0] SLOT_LAST = 3'h6;
  localparam logic [2:0] CLK_HIGH_SLOTS = 3'h4;

  // ----------------------------------------------------------------
  // line and frame timing, in lane clocks and lines
  // ----------------------------------------------------------------
  localparam logic [15:0] H_ACTIVE = 16'h0280;
  localparam logic [15:0] H_TOTAL_MIN = 16'h02AC;
  localparam logic [15:0] H_TOTAL_TYP = 16'h02BA;
  localparam logic [15:0] H_TOTAL_MAX = 16'h03F1;
  localparam logic [15:0] H_SYNC_START = 16'h0290;
  localparam logic [15:0] H_SYNC_END = 16'h02A0;
  localparam logic [15:0] V_ACTIVE = 16'h0810;
  localparam logic [15:0] V_TOTAL_MIN = 16'h0826;
  localparam logic [15:0] V_TOTAL_TYP = 16'h082A;
  localparam logic [15:0] V_TOTAL_MAX = 16'h090D;
  localparam logic [15:0] V_SYNC_START = 16'h0812;
  localparam logic [15:0] V_SYNC_END = 16'h0814;

  // ----------------------------------------------------------------
  // lane clock figures
  // ----------------------------------------------------------------
  localparam int LANE_FREQ_MIN_KHZ = 68270;
  localparam int LANE_FREQ_TYP_KHZ = 72940;
  localparam int LANE_FREQ_MAX_KHZ = 74690;
  localparam int RX_PERIOD_MIN_PS = 13390;
  localparam int RX_PERIOD_MAX_PS = 14640;
  localparam int RX_MARGIN_PS = 500;
  localparam int MCLK_PERIOD_PS = 5000;
  // a slot is far shorter than one system clock, so this floors at one
  localparam int SLOT_CYC_RAW = RX_PERIOD_MIN_PS / (SLOTS * MCLK_PERIOD_PS);
  localparam int LANE_SLOT_CYC = (SLOT_CYC_RAW < 1) ? 1 : SLOT_CYC_RAW;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [COLOR_W-1:0] red;
    logic [COLOR_W-1:0] green;
    logic [COLOR_W-1:0] blue;
  } qpl_pixel_t;

  typedef struct packed {
    logic clk;
    logic [LANES-1:0] lane;
  } qpl_port_t;

  typedef enum logic [5:0] {
    PS_OFF = 6'b000001,
    PS_SUPPLY = 6'b000010,
    PS_LINK = 6'b000100,
    PS_RUN = 6'b001000,
    PS_BL_DOWN = 6'b010000,
    PS_LINK_DOWN = 6'b100000
  } qpl_pwr_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } qpl_sync_state_t;

  typedef struct packed {
    qpl_pwr_t pwr;
    logic [31:0] wait_cnt;
    logic [7:0] frames;
    logic [2:0] slot;
    logic [7:0] sub;
    logic [15:0] h;
    logic [15:0] v;
    logic link_clk;
    logic link_en;
    logic supply_en;
    logic bl_on;
    logic dim_sel;
    logic pix_taken;
    logic frame_start;
  } qpl_top_state_t;

endpackage : qpl_pkg

// *** hdl/qpl_sync.sv ***
// qpl_sync: three-stage input synchroniser for a level from a pin.
// assumes rst_n is already synchronous to clk.
`timescale 1ns/100ps
module qpl_sync import qpl_pkg::*; #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);

  qpl_sync_state_t s;
  qpl_sync_state_t next_s;

  // ----------------------------------------------------------------
  // a change counts once the last two stages agree
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.s1 = pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3) begin
      next_s.level = s.s3;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, level: RESET_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;

endmodule : qpl_sync

// *** hdl/qpl_serializer.sv ***
// qpl_serializer: seven-to-one serialiser for the data lanes of one port.
// assumes load and shift come from the controller's slot sequencer.
`timescale 1ns/100ps
module qpl_serializer import qpl_pkg::*; #(
  parameter int NLANES = LANES,
  parameter int NSLOTS = SLOTS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic load,
  input wire logic shift,
  input wire logic [NLANES-1:0][NSLOTS-1:0] word,
  output logic [NLANES-1:0] lane
);

  typedef struct packed {
    logic [NLANES-1:0][NSLOTS-1:0] rest;
    logic [NLANES-1:0] out;
  } qpl_ser_state_t;

  qpl_ser_state_t s;
  qpl_ser_state_t next_s;

  // ----------------------------------------------------------------
  // slot 0 goes out first, right at the clock's rising edge
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (!enable) begin
      next_s = '0;
    end else if (load) begin
      for (int i = 0; i < NLANES; i++) begin
        next_s.out[i] = word[i][0];
        next_s.rest[i] = word[i] >> 1;
      end
    end else if (shift) begin
      for (int i = 0; i < NLANES; i++) begin
        next_s.out[i] = s.rest[i][0];
        next_s.rest[i] = s.rest[i] >> 1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign lane = s.out;

endmodule : qpl_serializer

// *** hdl/qpl_source.sv ***
// qpl_source: video source controller for a two-port seven-to-one pixel link,
// with panel supply, link and backlight power sequencing.
// assumes DISPLAY_ON, DIM_PWM and the pixel inputs are on MCLK; the backlight
// supply sense is an asynchronous pin.
`timescale 1ns/100ps

// Summary of operation
// - Each lane carries seven bits per clock: lane0 red 4-9 and green 4, lane1 green 5-9 and blue 4-5, lane2 blue 6-9 then line sync, frame sync and data enable, lane3 colour bits 2-3, lane4 colour bits 0-1, the last slot of lanes 3 and 4 unused.
// - Each port's lane clock must run between 68.27 MHz and 74.69 MHz, typically 72.94 MHz; at one 200 MHz MCLK per slot the code runs it at about 28.57 MHz.
// - A line lasts 684 to 1009 clocks, typically 698, with exactly 640 clocks of data enable.
// - A frame lasts 2086 to 2317 lines, typically 2090, with exactly 2064 active lines.
// - A frame is always a whole number of lines.
// - The lane clock period lies between 13.39 ns and 14.64 ns, high for four sevenths and low for three, framing the seven bit slots; the code's period is 35 ns.
// - Bit k sits at k sevenths of the period after the reference edge, within 0.5 ns.
// - All link lines stay low outside the valid period of the power sequence.
// - When the link signals stop, the panel supply is removed as well.
// - The backlight is switched on only after valid video has started.
// - Dimming select is low whenever the backlight supply is absent or the backlight is off.
module qpl_source import qpl_pkg::*; #(
  parameter int SLOT_CYC = LANE_SLOT_CYC,
  parameter logic [15:0] H_TOTAL = H_TOTAL_TYP,
  parameter logic [15:0] V_TOTAL = V_TOTAL_TYP,
  parameter int SUPPLY_TO_LINK_CYC = 200,
  parameter logic [7:0] BL_DELAY_FRAMES = 8'h02,
  parameter int BL_OFF_TO_LINK_CYC = 200,
  parameter int LINK_TO_SUPPLY_OFF_CYC = 200
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic DISPLAY_ON,
  input wire logic DIM_PWM,
  input wire logic BL_SUPPLY_OK,
  input qpl_pixel_t PIX_A,
  input qpl_pixel_t PIX_B,
  output logic PIX_TAKEN,
  output logic FRAME_START,
  output logic LINK_VALID,
  output logic PANEL_SUPPLY_EN,
  output logic BACKLIGHT_ON,
  output logic DIMMING_SELECT,
  output qpl_port_t LINK_A,
  output qpl_port_t LINK_B
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // backlight supply sense
  // ----------------------------------------------------------------
  logic bl_ok;

  qpl_sync #(
    .RESET_VAL(1'b0)
  ) u_bl_sync (
    .clk(MCLK),
    .rst_n(rst_n),
    .pin(BL_SUPPLY_OK),
    .level(bl_ok)
  );

  // ----------------------------------------------------------------
  // lane mapping
  // ----------------------------------------------------------------
  function automatic logic [LANES-1:0][SLOTS-1:0] map_lanes(
    input qpl_pixel_t p,
    input logic hs,
    input logic vs,
    input logic de
  );
    logic [LANES-1:0][SLOTS-1:0] w;
    w[0] = {p.green[4], p.red[9:4]};
    w[1] = {p.blue[5:4], p.green[9:5]};
    w[2] = {de, vs, hs, p.blue[9:6]};
    w[3] = {1'b0, p.blue[3:2], p.green[3:2], p.red[3:2]};
    w[4] = {1'b0, p.blue[1:0], p.green[1:0], p.red[1:0]};
    return w;
  endfunction : map_lanes

  localparam logic [7:0] SUB_LAST = 8'(SLOT_CYC - 1);
  localparam logic [31:0] SUP_WAIT = 32'(SUPPLY_TO_LINK_CYC - 1);
  localparam logic [31:0] BL_WAIT = 32'(BL_OFF_TO_LINK_CYC - 1);
  localparam logic [31:0] OFF_WAIT = 32'(LINK_TO_SUPPLY_OFF_CYC - 1);

  qpl_top_state_t s;
  qpl_top_state_t next_s;
  logic load;
  logic shift;
  logic frame_wrap;
  logic line_de;
  logic line_hs;
  logic line_vs;
  qpl_pixel_t pix_a;
  qpl_pixel_t pix_b;
  logic [LANES-1:0][SLOTS-1:0] word_a;
  logic [LANES-1:0][SLOTS-1:0] word_b;

  // ----------------------------------------------------------------
  // slot sequencer, raster counters and power sequence
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.pix_taken = 1'b0;
    next_s.frame_start = 1'b0;
    load = 1'b0;
    shift = 1'b0;
    frame_wrap = 1'b0;
    line_de = (s.h < H_ACTIVE) && (s.v < V_ACTIVE);
    line_hs = (s.h >= H_SYNC_START) && (s.h < H_SYNC_END);
    line_vs = (s.v >= V_SYNC_START) && (s.v < V_SYNC_END);
    // blanked pixels go out as zeros so stale data never leaks
    pix_a = line_de ? PIX_A : '0;
    pix_b = line_de ? PIX_B : '0;
    word_a = map_lanes(pix_a, line_hs, line_vs, line_de);
    word_b = map_lanes(pix_b, line_hs, line_vs, line_de);

    if (s.link_en) begin
      if (s.sub == SUB_LAST) begin
        next_s.sub = '0;
        if (s.slot == SLOT_LAST) begin
          next_s.slot = '0;
          load = 1'b1;
        end else begin
          next_s.slot = s.slot + 3'h1;
          shift = 1'b1;
        end
      end else begin
        next_s.sub = s.sub + 8'h01;
      end
      next_s.link_clk = (next_s.slot < CLK_HIGH_SLOTS);
    end else begin
      // parked so the first enabled cycle starts a clock period
      next_s.sub = SUB_LAST;
      next_s.slot = SLOT_LAST;
      next_s.link_clk = 1'b0;
      next_s.h = '0;
      next_s.v = '0;
    end

    if (load) begin
      next_s.pix_taken = line_de;
      next_s.frame_start = (s.h == '0) && (s.v == '0);
      if (s.h == H_TOTAL - 16'h0001) begin
        next_s.h = '0;
        // lines only advance at line end, so frames hold whole lines
        if (s.v == V_TOTAL - 16'h0001) begin
          next_s.v = '0;
          frame_wrap = 1'b1;
        end else begin
          next_s.v = s.v + 16'h0001;
        end
      end else begin
        next_s.h = s.h + 16'h0001;
      end
    end

    case (s.pwr)
      PS_OFF: begin
        next_s.wait_cnt = '0;
        if (DISPLAY_ON) begin
          next_s.pwr = PS_SUPPLY;
          next_s.supply_en = 1'b1;
        end
      end
      PS_SUPPLY: begin
        next_s.wait_cnt = s.wait_cnt + 32'h1;
        if (!DISPLAY_ON) begin
          next_s.pwr = PS_LINK_DOWN;
          next_s.wait_cnt = '0;
        end else if (s.wait_cnt == SUP_WAIT) begin
          next_s.pwr = PS_LINK;
          next_s.link_en = 1'b1;
          next_s.frames = '0;
        end
      end
      PS_LINK: begin
        if (frame_wrap && s.frames != BL_DELAY_FRAMES) begin
          next_s.frames = s.frames + 8'h01;
        end
        if (!DISPLAY_ON) begin
          next_s.pwr = PS_BL_DOWN;
          next_s.wait_cnt = '0;
        end else if (s.frames == BL_DELAY_FRAMES && bl_ok) begin
          next_s.pwr = PS_RUN;
          next_s.bl_on = 1'b1;
        end
      end
      PS_RUN: begin
        if (!DISPLAY_ON) begin
          next_s.pwr = PS_BL_DOWN;
          next_s.bl_on = 1'b0;
          next_s.wait_cnt = '0;
        end else if (!bl_ok) begin
          // supply lost: wait for video to settle again before relighting
          next_s.pwr = PS_LINK;
          next_s.bl_on = 1'b0;
          next_s.frames = '0;
        end
      end
      PS_BL_DOWN: begin
        next_s.bl_on = 1'b0;
        next_s.wait_cnt = s.wait_cnt + 32'h1;
        if (s.wait_cnt == BL_WAIT) begin
          next_s.pwr = PS_LINK_DOWN;
          next_s.link_en = 1'b0;
          next_s.wait_cnt = '0;
        end
      end
      PS_LINK_DOWN: begin
        next_s.link_en = 1'b0;
        next_s.wait_cnt = s.wait_cnt + 32'h1;
        if (s.wait_cnt == OFF_WAIT) begin
          next_s.pwr = PS_OFF;
          next_s.supply_en = 1'b0;
          next_s.wait_cnt = '0;
        end
      end
      default: begin
        next_s.pwr = PS_OFF;
        next_s.link_en = 1'b0;
        next_s.supply_en = 1'b0;
        next_s.bl_on = 1'b0;
      end
    endcase

    // lane clock drops with LINK_VALID, never a cycle after it
    if (!next_s.link_en) begin
      next_s.link_clk = 1'b0;
    end

    // low means pwm dimming; forced low while dark or unpowered
    next_s.dim_sel = next_s.bl_on && bl_ok && !DIM_PWM;
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{pwr: PS_OFF, slot: SLOT_LAST, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // serialisers, port A carries even pixels and port B odd ones
  // ----------------------------------------------------------------
  logic [LANES-1:0] lanes_a;
  logic [LANES-1:0] lanes_b;

  qpl_serializer #(
    .NLANES(LANES),
    .NSLOTS(SLOTS)
  ) u_ser_a (
    .clk(MCLK),
    .rst_n(rst_n),
    .enable(next_s.link_en),
    .load(load),
    .shift(shift),
    .word(word_a),
    .lane(lanes_a)
  );

  qpl_serializer #(
    .NLANES(LANES),
    .NSLOTS(SLOTS)
  ) u_ser_b (
    .clk(MCLK),
    .rst_n(rst_n),
    .enable(next_s.link_en),
    .load(load),
    .shift(shift),
    .word(word_b),
    .lane(lanes_b)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // both ports share one sequencer, so their timing is identical
  assign LINK_A = '{clk: s.link_clk, lane: lanes_a};
  assign LINK_B = '{clk: s.link_clk, lane: lanes_b};
  assign PIX_TAKEN = s.pix_taken;
  assign FRAME_START = s.frame_start;
  assign LINK_VALID = s.link_en;
  assign PANEL_SUPPLY_EN = s.supply_en;
  assign BACKLIGHT_ON = s.bl_on;
  assign DIMMING_SELECT = s.dim_sel;

endmodule : qpl_source

// *** verification/qpl_source_asserts.sv ***
// qpl_source_asserts: port timing checks for the pixel link source.
// assumes it is bound into qpl_source; every port but BL_SUPPLY_OK sits on MCLK.
`timescale 1ns/100ps
module qpl_source_asserts import qpl_pkg::*; #(
  parameter int SLOT_CYC = LANE_SLOT_CYC,
  parameter logic [15:0] H_TOTAL = H_TOTAL_TYP,
  parameter logic [15:0] V_TOTAL = V_TOTAL_TYP,
  parameter int SUPPLY_TO_LINK_CYC = 200,
  parameter logic [7:0] BL_DELAY_FRAMES = 8'h02,
  parameter int LINK_TO_SUPPLY_OFF_CYC = 200
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic DISPLAY_ON,
  input wire logic DIM_PWM,
  input wire logic BL_SUPPLY_OK,
  input wire logic PIX_TAKEN,
  input wire logic LINK_VALID,
  input wire logic PANEL_SUPPLY_EN,
  input wire logic BACKLIGHT_ON,
  input wire logic DIMMING_SELECT,
  input wire qpl_port_t LINK_A,
  input wire qpl_port_t LINK_B
);
  // one load of slack: the frame wrap lands on a load edge
  localparam int BL_MIN = 7 * SLOT_CYC * H_TOTAL * V_TOTAL * BL_DELAY_FRAMES - 7;
  logic [31:0] up_cyc;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      up_cyc <= 32'h0;
    end else begin
      up_cyc <= LINK_VALID ? up_cyc + 32'h1 : 32'h0;
    end
  end

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  // ----------------------------------------------------------------
  // link lines
  // ----------------------------------------------------------------
  property p_link_quiet;
    !LINK_VALID |-> LINK_A == '0 && LINK_B == '0;
  endproperty
  a_link_quiet: assert property (p_link_quiet) else $error("link active while invalid");
  property p_supply_lead;
    $rose(LINK_VALID) |-> $past(PANEL_SUPPLY_EN, SUPPLY_TO_LINK_CYC)
      && !$past(PANEL_SUPPLY_EN, SUPPLY_TO_LINK_CYC + 1);
  endproperty
  a_supply_lead: assert property (p_supply_lead) else $error("link started off schedule");
  property p_link_supply;
    LINK_VALID |-> PANEL_SUPPLY_EN;
  endproperty
  a_link_supply: assert property (p_link_supply) else $error("link without panel supply");
  property p_supply_tail;
    $fell(PANEL_SUPPLY_EN) |-> !LINK_VALID && !$past(LINK_VALID, LINK_TO_SUPPLY_OFF_CYC);
  endproperty
  a_supply_tail: assert property (p_supply_tail) else $error("supply cut too early");
  property p_ports_aligned;
    LINK_A.clk == LINK_B.clk;
  endproperty
  a_ports_aligned: assert property (p_ports_aligned) else $error("port clocks differ");
  property p_clk_shape;
    ($rose(LINK_A.clk) ##1 LINK_VALID [*7]) |-> LINK_A.clk && !$past(LINK_A.clk, 1)
      && !$past(LINK_A.clk, 2) && !$past(LINK_A.clk, 3) && $past(LINK_A.clk, 4)
      && $past(LINK_A.clk, 5) && $past(LINK_A.clk, 6);
  endproperty
  a_clk_shape: assert property (p_clk_shape) else $error("lane clock not 4 high 3 low");
  property p_slot_unused;
    (!LINK_A.clk && !$past(LINK_A.clk, 2) && $past(LINK_A.clk, 3))
      |-> LINK_A.lane[4:3] == 2'h0 && LINK_B.lane[4:3] == 2'h0;
  endproperty
  a_slot_unused: assert property (p_slot_unused) else $error("unused slot not low");
  property p_taken_slot0;
    PIX_TAKEN |-> LINK_A.clk && !$past(LINK_A.clk);
  endproperty
  a_taken_slot0: assert property (p_taken_slot0) else $error("pixel not at slot 0");

  // ----------------------------------------------------------------
  // backlight
  // ----------------------------------------------------------------
  property p_bl_video;
    BACKLIGHT_ON |-> LINK_VALID;
  endproperty
  a_bl_video: assert property (p_bl_video) else $error("backlight without video");
  property p_bl_frames;
    $rose(BACKLIGHT_ON) |-> up_cyc >= BL_MIN;
  endproperty
  a_bl_frames: assert property (p_bl_frames) else $error("backlight before frames ran");
  property p_bl_down;
    !DISPLAY_ON |=> !BACKLIGHT_ON;
  endproperty
  a_bl_down: assert property (p_bl_down) else $error("backlight held after stop");
  property p_dim_rule;
    DIMMING_SELECT |-> BACKLIGHT_ON && !$past(DIM_PWM);
  endproperty
  a_dim_rule: assert property (p_dim_rule) else $error("dimming select high wrongly");
  property p_dim_supply;
    !BL_SUPPLY_OK [*6] |-> !DIMMING_SELECT && !BACKLIGHT_ON;
  endproperty
  a_dim_supply: assert property (p_dim_supply) else $error("backlight kept without supply");
endmodule : qpl_source_asserts

bind qpl_source qpl_source_asserts #(.SLOT_CYC(SLOT_CYC), .H_TOTAL(H_TOTAL),
  .V_TOTAL(V_TOTAL), .SUPPLY_TO_LINK_CYC(SUPPLY_TO_LINK_CYC),
  .BL_DELAY_FRAMES(BL_DELAY_FRAMES), .LINK_TO_SUPPLY_OFF_CYC(LINK_TO_SUPPLY_OFF_CYC))
  i_qpl_source_asserts (.MCLK(MCLK), .RST_N(RST_N), .DISPLAY_ON(DISPLAY_ON),
  .DIM_PWM(DIM_PWM), .BL_SUPPLY_OK(BL_SUPPLY_OK), .PIX_TAKEN(PIX_TAKEN),
  .LINK_VALID(LINK_VALID), .PANEL_SUPPLY_EN(PANEL_SUPPLY_EN), .BACKLIGHT_ON(BACKLIGHT_ON),
  .DIMMING_SELECT(DIMMING_SELECT), .LINK_A(LINK_A), .LINK_B(LINK_B));

// *** verification/qpl_panel_model.sv ***
// qpl_panel_model: panel receiver; decodes both ports of the link.
// assumes one slot per MCLK; finds lane clock edges by sampling.
`timescale 1ns/100ps
module qpl_panel_model import qpl_pkg::*; (
  input wire logic clk,
  input wire qpl_port_t link_a,
  input wire qpl_port_t link_b,
  output logic rx_valid,
  output qpl_pixel_t rx_a,
  output qpl_pixel_t rx_b,
  output logic rx_de,
  output logic rx_sync_ok,
  output logic rx_line_done,
  output logic [15:0] rx_line_px,
  output logic [15:0] rx_line_len
);
  logic [LANES-1:0][SLOTS-1:0] wa;
  logic [LANES-1:0][SLOTS-1:0] wb;
  logic prev_clk = 1'b0;
  logic prev_de = 1'b0;
  int slot = 7;
  int hi = 0;
  logic [15:0] px = 16'h0;
  logic [15:0] len = 16'h0;

  function automatic qpl_pixel_t unpack(input logic [LANES-1:0][SLOTS-1:0] w);
    unpack.red = {w[0][5:0], w[3][1:0], w[4][1:0]};
    unpack.green = {w[1][4:0], w[0][6], w[3][3:2], w[4][3:2]};
    unpack.blue = {w[2][3:0], w[1][6:5], w[3][5:4], w[4][5:4]};
  endfunction : unpack

  always @(posedge clk) begin
    rx_valid <= 1'b0;
    rx_line_done <= 1'b0;
    if (link_a.clk && !prev_clk) begin
      slot = 0;
      hi = 0;
    end else if (slot < 7) begin
      slot = slot + 1;
    end
    prev_clk = link_a.clk;
    hi = hi + int'(link_a.clk);
    if (slot < 7) begin
      for (int l = 0; l < LANES; l++) begin
        wa[l][slot] = link_a.lane[l];
        wb[l][slot] = link_b.lane[l];
      end
    end
    // a word cut short by a stopped link before slot 4 is dropped
    if (slot == 6 && hi == 4) begin
      rx_valid <= 1'b1;
      rx_a <= unpack(wa);
      rx_b <= unpack(wb);
      rx_de <= wa[2][6];
      rx_sync_ok <= (wa[2][6:4] == wb[2][6:4]);
      len = len + 16'h1;
      if (wa[2][6] && !prev_de) begin
        rx_line_done <= 1'b1;
        rx_line_px <= px;
        rx_line_len <= len;
        px = 16'h0;
        len = 16'h0;
      end
      if (wa[2][6]) px = px + 16'h1;
      prev_de = wa[2][6];
    end
  end
endmodule : qpl_panel_model

// *** verification/qpl_source_tb.sv ***
// qpl_source_tb: self-checking bench for the pixel link source.
// assumes the panel model decodes the link; pixels are random.
`timescale 1ns/100ps
module qpl_source_tb;
  import qpl_pkg::*;
  localparam logic [15:0] HT = H_TOTAL_MIN;
  localparam logic [15:0] VT = 16'h0004;
  localparam int FRAME_CYC = 7 * HT * VT;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic DISPLAY_ON = 1'b0;
  logic DIM_PWM = 1'b0;
  logic BL_SUPPLY_OK = 1'b0;
  qpl_pixel_t PIX_A = '0;
  qpl_pixel_t PIX_B = '0;
  logic PIX_TAKEN, FRAME_START, LINK_VALID, PANEL_SUPPLY_EN, BACKLIGHT_ON, DIMMING_SELECT;
  qpl_port_t LINK_A, LINK_B;
  logic rx_valid, rx_de, rx_sync_ok, rx_line_done;
  qpl_pixel_t rx_a, rx_b;
  logic [15:0] rx_line_px, rx_line_len;
  int errors = 0;
  int comparisons = 0;
  int frame_cnt = -1;
  bit line_seen = 0;
  logic [59:0] exp_q[$];

  always #2.5 MCLK = ~MCLK;

  qpl_source #(.SLOT_CYC(1), .H_TOTAL(HT), .V_TOTAL(VT), .SUPPLY_TO_LINK_CYC(4),
    .BL_DELAY_FRAMES(8'h01), .BL_OFF_TO_LINK_CYC(4), .LINK_TO_SUPPLY_OFF_CYC(4)) i_qpl_source (
    .MCLK(MCLK), .RST_N(RST_N), .DISPLAY_ON(DISPLAY_ON), .DIM_PWM(DIM_PWM),
    .BL_SUPPLY_OK(BL_SUPPLY_OK), .PIX_A(PIX_A), .PIX_B(PIX_B), .PIX_TAKEN(PIX_TAKEN),
    .FRAME_START(FRAME_START), .LINK_VALID(LINK_VALID), .PANEL_SUPPLY_EN(PANEL_SUPPLY_EN),
    .BACKLIGHT_ON(BACKLIGHT_ON), .DIMMING_SELECT(DIMMING_SELECT), .LINK_A(LINK_A),
    .LINK_B(LINK_B));

  qpl_panel_model i_qpl_panel_model (.clk(MCLK), .link_a(LINK_A), .link_b(LINK_B),
    .rx_valid(rx_valid), .rx_a(rx_a), .rx_b(rx_b), .rx_de(rx_de), .rx_sync_ok(rx_sync_ok),
    .rx_line_done(rx_line_done), .rx_line_px(rx_line_px), .rx_line_len(rx_line_len));

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic summarize;
    if (errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // pixel driver and result monitor
  // ----------------------------------------------------------------
  // a pair is held from one take to the next, so the load edge sees it
  always @(negedge MCLK) begin
    if (PIX_TAKEN === 1'b1) begin
      exp_q.push_back({PIX_A, PIX_B});
      PIX_A <= 30'($urandom());
      PIX_B <= 30'($urandom());
    end
  end

  always @(posedge MCLK) begin
    if (LINK_VALID !== 1'b1) begin
      exp_q.delete();
      line_seen = 0;
      frame_cnt = -1;
    end else begin
      if (rx_valid === 1'b1) begin
        if (rx_de === 1'b1) check("pixel", exp_q.size() ? exp_q.pop_front() : '1, {rx_a, rx_b});
        else check("blank pixel", 64'h0, {rx_a, rx_b});
        check("port sync", 64'h1, rx_sync_ok);
      end
      if (rx_line_done === 1'b1) begin
        if (line_seen) check("line length", HT, rx_line_len);
        if (line_seen) check("active pixels", H_ACTIVE, rx_line_px);
        line_seen = 1;
      end
      if (FRAME_START === 1'b1) begin
        if (frame_cnt >= 0) check("frame period", FRAME_CYC, frame_cnt + 1);
        frame_cnt = 0;
      end else if (frame_cnt >= 0) begin
        frame_cnt++;
      end
    end
  end

  initial begin
    repeat (100000) @(posedge MCLK);
    errors++;
    summarize();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    bit seen;
    void'($urandom(40));
    PIX_A = 30'($urandom());
    PIX_B = 30'($urandom());
    repeat (3) @(negedge MCLK);
    RST_N = 1'b1;
    repeat (3) @(negedge MCLK);
    DISPLAY_ON = 1'b1;
    BL_SUPPLY_OK = 1'b1;
    for (n = 0; n < 3 * FRAME_CYC && BACKLIGHT_ON !== 1'b1; n++) @(negedge MCLK);
    check("backlight on", 64'h1, BACKLIGHT_ON);
    check("dimming select", 64'h1, DIMMING_SELECT);
    repeat (14 * HT) @(negedge MCLK);
    DIM_PWM = 1'b1;
    repeat (2) @(negedge MCLK);
    check("dimming select pwm", 64'h0, DIMMING_SELECT);
    DIM_PWM = 1'b0;
    BL_SUPPLY_OK = 1'b0;
    repeat (10) @(negedge MCLK);
    check("backlight no supply", 64'h0, BACKLIGHT_ON);
    check("dimming no supply", 64'h0, DIMMING_SELECT);
    check("link kept", 64'h1, LINK_VALID);
    BL_SUPPLY_OK = 1'b1;
    for (n = 0; n < 3 * FRAME_CYC && BACKLIGHT_ON !== 1'b1; n++) @(negedge MCLK);
    check("backlight again", 64'h1, BACKLIGHT_ON);
    DISPLAY_ON = 1'b0;
    repeat (2) @(negedge MCLK);
    check("backlight off first", 64'h0, BACKLIGHT_ON);
    for (n = 0; n < 50 && PANEL_SUPPLY_EN !== 1'b0; n++) @(negedge MCLK);
    check("supply off", 64'h0, PANEL_SUPPLY_EN);
    check("link lines", 64'h0, {LINK_A, LINK_B, LINK_VALID});
    DISPLAY_ON = 1'b1;
    repeat (2) @(negedge MCLK);
    DISPLAY_ON = 1'b0;
    seen = 0;
    repeat (40) begin
      @(negedge MCLK);
      if (LINK_VALID !== 1'b0) seen = 1;
    end
    check("aborted start link", 64'h0, seen);
    check("aborted start supply", 64'h0, PANEL_SUPPLY_EN);
    DISPLAY_ON = 1'b1;
    repeat (20) @(negedge MCLK);
    RST_N = 1'b0;
    @(negedge MCLK);
    check("reset outputs", 64'h0, {LINK_A, LINK_VALID, PANEL_SUPPLY_EN});
    RST_N = 1'b1;
    DISPLAY_ON = 1'b0;
    repeat (20) @(negedge MCLK);
    summarize();
  end
endmodule : qpl_source_tb
